// ===== design/nfc_defs.vh
`ifndef NFC_DEFS_VH
`define NFC_DEFS_VH

// Flash command codes
`define NFC_CMD_READ        8'h00
`define NFC_CMD_PROG_CONF   8'h10
`define NFC_CMD_RD_COPYBACK 8'h35
`define NFC_CMD_ERASE_SETUP 8'h60
`define NFC_CMD_STATUS      8'h70
`define NFC_CMD_COPY_INPUT  8'h85
`define NFC_CMD_READ_ID     8'h90
`define NFC_CMD_ERASE_CONF  8'hD0
`define NFC_CMD_STATUS_PL   8'hF1
`define NFC_CMD_RESET       8'hFF
`define NFC_ID_ADDR         8'h00

// Status byte bit positions
`define NFC_ST_FAIL         0
`define NFC_ST_PL0_FAIL     1
`define NFC_ST_PL1_FAIL     2
`define NFC_ST_TRUE_RDY     5
`define NFC_ST_RDY          6
`define NFC_ST_WP_N         7
// Bits meaningful after 70h and after F1h
`define NFC_ST_MASK_70      8'hC1
`define NFC_ST_MASK_F1      8'hC7

// Page geometry and ID length
`define NFC_PAGE_BYTES      12'd2112
`define NFC_ID_BYTES        3'd5

// Register offsets (AXI4-Lite byte addresses)
`define NFC_REG_CTRL        4'h0
`define NFC_REG_ADDR        4'h4
`define NFC_REG_DATA        4'h8
`define NFC_REG_STAT        4'hC

// Control register fields
`define NFC_CTRL_OP_LSB     0
`define NFC_CTRL_CNT_LSB    4
`define NFC_CTRL_START      31

// Operation codes written to the control register
`define NFC_OP_RD_COPYBACK  3'd1
`define NFC_OP_COPY_PROG    3'd2
`define NFC_OP_ERASE        3'd3
`define NFC_OP_STATUS       3'd4
`define NFC_OP_STATUS_PL    3'd5
`define NFC_OP_READ_ID      3'd6
`define NFC_OP_RESET        3'd7

// Status register fields
`define NFC_STAT_BUSY       8
`define NFC_STAT_RB         9
`define NFC_STAT_FAIL       10
`define NFC_STAT_DAV        11

// Bus strobe width and hold time, in ns and in clk_sys cycles
`define NFC_T_STROBE_NS     24
`define NFC_T_STROBE_CYC    ((`NFC_T_STROBE_NS + 7) / 8)

// AXI responses
`define NFC_RESP_OKAY       2'b00
`define NFC_RESP_SLVERR     2'b10

`endif

// ===== design/nfc_pin_phy.v
`timescale 1ns/1ns
`default_nettype none
`include "nfc_defs.vh"

// One bus cycle on the flash pins: command, address, data write or data read
module nfc_pin_phy
(
   // Clock and reset
   input  wire       clk_sys,
   input  wire       nrst,
   // Request
   input  wire       req,
   input  wire [1:0] kind,
   input  wire [7:0] wdata,
   output reg        done,
   output reg  [7:0] rdata,
   // Pins
   output reg        cle,
   output reg        ale,
   output reg        write_strobe_n,
   output reg        read_strobe_n,
   output reg  [7:0] io_out,
   output reg        io_oe_n,
   input  wire [7:0] io_in
);
   localparam [1:0] K_CMD = 2'd0;
   localparam [1:0] K_ADR = 2'd1;
   localparam [1:0] K_WR  = 2'd2;
   localparam [1:0] K_RD  = 2'd3;
   localparam [1:0] P_IDLE = 2'd0;
   localparam [1:0] P_LOW  = 2'd1;
   localparam [1:0] P_HIGH = 2'd2;
   localparam integer T_CYC_I = `NFC_T_STROBE_CYC;
   localparam [3:0] T_CYC  = T_CYC_I[3:0];

   reg [1:0] ph_q;
   reg [3:0] cnt_q;
   reg [1:0] kind_q;
   reg [7:0] io_s1_q;
   reg [7:0] io_s2_q;

   always @(posedge clk_sys)
   begin
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
   end

   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         ph_q <= P_IDLE;
         cnt_q <= 4'h0;
         kind_q <= K_CMD;
         done <= 1'b0;
         rdata <= 8'h00;
         cle <= 1'b0;
         ale <= 1'b0;
         write_strobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
         io_out <= 8'h00;
         io_oe_n <= 1'b1;
      end
      else
      begin
         done <= 1'b0;
         case (ph_q)
            P_IDLE:
               if (req)
               begin
                  kind_q <= kind;
                  cle <= (kind == K_CMD);
                  ale <= (kind == K_ADR);
                  io_out <= wdata;
                  io_oe_n <= (kind == K_RD);
                  write_strobe_n <= (kind == K_RD);
                  read_strobe_n <= (kind != K_RD);
                  cnt_q <= T_CYC;
                  ph_q <= P_LOW;
               end
            P_LOW:
               if (cnt_q > 4'h1)
                  cnt_q <= cnt_q - 4'h1;
               else
               begin
                  // Capture late, after two-stage sync has settled
                  if (kind_q == K_RD)
                     rdata <= io_s2_q;
                  write_strobe_n <= 1'b1;
                  read_strobe_n <= 1'b1;
                  cnt_q <= T_CYC;
                  ph_q <= P_HIGH;
               end
            P_HIGH:
               if (cnt_q > 4'h1)
                  cnt_q <= cnt_q - 4'h1;
               else
               begin
                  cle <= 1'b0;
                  ale <= 1'b0;
                  io_oe_n <= 1'b1;
                  done <= 1'b1;
                  ph_q <= P_IDLE;
               end
            default:
               ph_q <= P_IDLE;
         endcase
      end
   end
endmodule // nfc_pin_phy
`default_nettype wire

// ===== design/nfc_seq_top.v
`timescale 1ns/1ns
`default_nettype none
`include "nfc_defs.vh"

//-----------------------------------------------------------------
// Host sequencer for copy-back, erase, status and ID
//-----------------------------------------------------------------
// Contract
// RL1: 35h plus source address loads page
// RL2: Buffered page may be read out
// RL3: 85h plus destination starts copy-back
// RL4: Replacement bytes may be loaded repeatedly
// RL5: Programming starts only on 10h
// RL6: Busy via ready/busy and bit 6
// RL7: Decoder stays in status mode after
// RL8: 60h then three row address cycles
// RL9: Erase starts on D0h confirm
// RL10: Erase end releases ready, bit 0
// RL11: 70h accepted right after D0h
// RL12: Status driven on each read cycle
// RL13: Status updates live in status mode
// RL14: 00h needed to resume data reads
// RL15: 70h status bit encoding
// RL16: F1h per-plane status bit encoding
// RL17: Host masks unused status bits
// RL18: 90h, 00h, then five ID bytes
// RL19: Decoder stays in ID mode
// RL20: FFh aborts, clears, status C0h
// RL21: Busy allows only status and reset
module nfc_seq_top
(
   // Clock and reset
   input  wire        clk_sys,
   input  wire        nrst,
   // AXI4-Lite write
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Flash pins
   output wire        cle,
   output wire        ale,
   output wire        write_strobe_n,
   output wire        read_strobe_n,
   output wire [7:0]  io_out,
   output wire        io_oe_n,
   input  wire [7:0]  io_in,
   input  wire        ready_busy_n
);
   localparam [3:0] S_IDLE  = 4'd0;
   localparam [3:0] S_CMD1  = 4'd1;
   localparam [3:0] S_ADDR  = 4'd2;
   localparam [3:0] S_CMD2  = 4'd3;
   localparam [3:0] S_WAIT  = 4'd4;
   localparam [3:0] S_XFER  = 4'd5;
   localparam [3:0] S_POLL  = 4'd6;
   localparam [3:0] S_PRD   = 4'd7;
   localparam [1:0] K_CMD = 2'd0;
   localparam [1:0] K_ADR = 2'd1;
   localparam [1:0] K_WR  = 2'd2;
   localparam [1:0] K_RD  = 2'd3;

   //-----------------------------------------------------------------
   // Registers
   //-----------------------------------------------------------------
   reg  [3:0]  st_q;
   reg  [2:0]  op_q;
   reg  [11:0] cnt_q;
   reg  [11:0] xfer_q;
   reg  [39:0] addr_q;
   reg  [2:0]  acnt_q;
   reg  [2:0]  anum_q;
   reg  [7:0]  wbyte_q;
   reg         wfull_q;
   reg  [7:0]  rbyte_q;
   reg         dav_q;
   reg  [7:0]  status_q;
   reg         fail_q;
   reg         rb_s1_q;
   reg         rb_s2_q;
   reg         req_q;
   reg  [1:0]  kind_q;
   reg  [7:0]  pdata_q;
   reg  [31:0] wd_q;
   reg  [3:0]  wa_q;
   reg         have_aw_q;
   reg         have_w_q;
   wire        ph_done;
   wire [7:0]  ph_rdata;

   // First-cycle command code per operation
   function [7:0] op_cmd1;
      input [2:0] op;
      begin
         case (op)
            `NFC_OP_RD_COPYBACK: op_cmd1 = `NFC_CMD_READ;          // [RL14]
            `NFC_OP_COPY_PROG:   op_cmd1 = `NFC_CMD_COPY_INPUT;    // [RL3]
            `NFC_OP_ERASE:       op_cmd1 = `NFC_CMD_ERASE_SETUP;   // [RL8]
            `NFC_OP_STATUS:      op_cmd1 = `NFC_CMD_STATUS;
            `NFC_OP_STATUS_PL:   op_cmd1 = `NFC_CMD_STATUS_PL;
            `NFC_OP_READ_ID:     op_cmd1 = `NFC_CMD_READ_ID;       // [RL18]
            default:             op_cmd1 = `NFC_CMD_RESET;         // [RL20]
         endcase
      end
   endfunction

   nfc_pin_phy u_phy
   (
      .clk_sys        (clk_sys),
      .nrst           (nrst),
      .req            (req_q),
      .kind           (kind_q),
      .wdata          (pdata_q),
      .done           (ph_done),
      .rdata          (ph_rdata),
      .cle            (cle),
      .ale            (ale),
      .write_strobe_n (write_strobe_n),
      .read_strobe_n  (read_strobe_n),
      .io_out         (io_out),
      .io_oe_n        (io_oe_n),
      .io_in          (io_in)
   );

   always @(posedge clk_sys)
   begin
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
   end

   //-----------------------------------------------------------------
   // AXI4-Lite slave and sequencer
   //-----------------------------------------------------------------
   wire wr_go = have_aw_q && have_w_q && !s_axi_bvalid;
   wire ctrl_go = wr_go && (wa_q == `NFC_REG_CTRL) && wd_q[`NFC_CTRL_START] && s_axi_wstrb[3];
   wire op_busy = (st_q != S_IDLE);
   wire [2:0] w_op = wd_q[2:0];

   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `NFC_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `NFC_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         have_aw_q <= 1'b0;
         have_w_q <= 1'b0;
         wa_q <= 4'h0;
         wd_q <= 32'h0000_0000;
         st_q <= S_IDLE;
         op_q <= 3'd0;
         cnt_q <= 12'h000;
         xfer_q <= 12'h000;
         addr_q <= 40'h00_0000_0000;
         acnt_q <= 3'd0;
         anum_q <= 3'd0;
         wbyte_q <= 8'h00;
         wfull_q <= 1'b0;
         rbyte_q <= 8'h00;
         dav_q <= 1'b0;
         status_q <= 8'h00;
         fail_q <= 1'b0;
         req_q <= 1'b0;
         kind_q <= K_CMD;
         pdata_q <= 8'h00;
      end
      else
      begin
         req_q <= 1'b0;
         s_axi_awready <= !have_aw_q && s_axi_awvalid && !s_axi_awready;
         s_axi_wready <= !have_w_q && s_axi_wvalid && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            have_aw_q <= 1'b1;
            wa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            have_w_q <= 1'b1;
            wd_q <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_go)
         begin
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa_q == `NFC_REG_STAT) ? `NFC_RESP_SLVERR : `NFC_RESP_OKAY;
            if (wa_q == `NFC_REG_ADDR)
               addr_q[31:0] <= wd_q;
            if (wa_q == `NFC_REG_DATA)
            begin
               // Patch bytes for copy-back; a new write overwrites wbyte_q even if wfull_q is set
               wbyte_q <= wd_q[7:0];   // [RL4]
               wfull_q <= 1'b1;
            end
         end
         // Read channel, one outstanding read
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `NFC_RESP_OKAY;
            case (s_axi_araddr)
               `NFC_REG_CTRL: s_axi_rdata <= {20'h00000, xfer_q};
               `NFC_REG_ADDR: s_axi_rdata <= addr_q[31:0];
               `NFC_REG_DATA: s_axi_rdata <= {23'h000000, dav_q, rbyte_q};
               `NFC_REG_STAT: s_axi_rdata <= {20'h00000, dav_q, fail_q, rb_s2_q, op_busy, status_q};
               default:       s_axi_rresp <= `NFC_RESP_SLVERR;
            endcase
            if (s_axi_araddr == `NFC_REG_DATA)
               dav_q <= 1'b0;
         end

         case (st_q)
            S_IDLE:
               if (ctrl_go)
               begin
                  op_q <= w_op;
                  xfer_q <= (w_op == `NFC_OP_READ_ID) ? {9'h000, `NFC_ID_BYTES} : wd_q[15:4];
                  cnt_q <= 12'h000;
                  acnt_q <= 3'd0;
                  // Erase takes row address only, page bits ignored by device
                  anum_q <= (w_op == `NFC_OP_ERASE) ? 3'd3 :       // [RL8]
                            (w_op == `NFC_OP_READ_ID) ? 3'd1 :
                            (w_op >= `NFC_OP_STATUS) ? 3'd0 : 3'd5;
                  pdata_q <= op_cmd1(w_op);
                  kind_q <= K_CMD;
                  req_q <= 1'b1;
                  st_q <= S_CMD1;
               end
            S_CMD1:
               if (ph_done)
               begin
                  if (anum_q != 3'd0)
                  begin
                     kind_q <= K_ADR;
                     // Erase skips the two column bytes
                     pdata_q <= (op_q == `NFC_OP_READ_ID) ? `NFC_ID_ADDR :   // [RL18]
                                (op_q == `NFC_OP_ERASE) ? addr_q[23:16] : addr_q[7:0];
                     if (op_q == `NFC_OP_ERASE)
                        addr_q <= {16'h0000, addr_q[39:16]};
                     req_q <= 1'b1;
                     st_q <= S_ADDR;
                  end
                  else if (op_q == `NFC_OP_RESET)
                     st_q <= S_WAIT;   // [RL20]
                  else if (op_q == `NFC_OP_STATUS || op_q == `NFC_OP_STATUS_PL)
                  begin
                     kind_q <= K_RD;   // [RL12]
                     req_q <= 1'b1;
                     st_q <= S_POLL;
                  end
                  else
                     st_q <= S_IDLE;
               end
            S_ADDR:
               if (ph_done)
               begin
                  if (acnt_q + 3'd1 < anum_q)
                  begin
                     acnt_q <= acnt_q + 3'd1;
                     pdata_q <= addr_q[15:8];
                     addr_q <= {8'h00, addr_q[39:8]};
                     req_q <= 1'b1;
                  end
                  else if (op_q == `NFC_OP_READ_ID)
                  begin
                     kind_q <= K_RD;   // [RL19]
                     req_q <= 1'b1;
                     st_q <= S_XFER;
                  end
                  else
                  begin
                     kind_q <= K_CMD;
                     pdata_q <= (op_q == `NFC_OP_RD_COPYBACK) ? `NFC_CMD_RD_COPYBACK :   // [RL1]
                                (op_q == `NFC_OP_ERASE) ? `NFC_CMD_ERASE_CONF :        // [RL9]
                                8'h00;
                     // Copy-back program loads patch data before confirming
                     if (op_q == `NFC_OP_COPY_PROG)
                        st_q <= S_XFER;   // [RL4]
                     else
                     begin
                        req_q <= 1'b1;
                        st_q <= S_CMD2;
                     end
                  end
               end
            S_CMD2:
               if (ph_done)
                  st_q <= S_WAIT;
            S_WAIT:
               // Device is busy; only a status read or reset may follow
               if (rb_s2_q)   // [RL21]
               begin
                  if (op_q == `NFC_OP_RD_COPYBACK)
                  begin
                     kind_q <= K_RD;   // [RL2]
                     if (xfer_q != 12'h000)
                        req_q <= 1'b1;
                     st_q <= (xfer_q != 12'h000) ? S_XFER : S_IDLE;
                  end
                  else if (op_q == `NFC_OP_RESET)
                     st_q <= S_IDLE;
                  else
                  begin
                     // Status read after program or erase, sent once ready returns
                     kind_q <= K_CMD;   // [RL11]
                     pdata_q <= `NFC_CMD_STATUS;
                     op_q <= `NFC_OP_STATUS;
                     req_q <= 1'b1;
                     st_q <= S_PRD;
                  end
               end
            S_XFER:
               if (kind_q == K_RD)
               begin
                  // No back-pressure: software must drain data in time
                  if (ph_done)
                  begin
                     rbyte_q <= ph_rdata;
                     dav_q <= 1'b1;
                     cnt_q <= cnt_q + 12'h001;
                     if (cnt_q + 12'h001 < xfer_q)
                        req_q <= 1'b1;
                     else
                        st_q <= S_IDLE;
                  end
               end
               else if (cnt_q >= xfer_q && kind_q != K_WR)
               begin
                  // Confirm only after the last patch byte has left the pins
                  kind_q <= K_CMD;
                  pdata_q <= `NFC_CMD_PROG_CONF;   // [RL5]
                  req_q <= 1'b1;
                  st_q <= S_CMD2;
               end
               else if (cnt_q < xfer_q && !req_q && (kind_q == K_WR ? ph_done : 1'b1) && wfull_q)
               begin
                  kind_q <= K_WR;
                  pdata_q <= wbyte_q;
                  wfull_q <= (wr_go && wa_q == `NFC_REG_DATA);
                  cnt_q <= cnt_q + 12'h001;
                  req_q <= 1'b1;
               end
               else if (kind_q == K_WR && ph_done)
                  kind_q <= K_ADR;
            S_PRD:
               if (ph_done)
               begin
                  kind_q <= K_RD;
                  req_q <= 1'b1;
                  st_q <= S_POLL;
               end
            S_POLL:
               if (ph_done)
               begin
                  // Mask unused bits before use
                  status_q <= ph_rdata & ((op_q == `NFC_OP_STATUS_PL) ?
                              `NFC_ST_MASK_F1 : `NFC_ST_MASK_70);   // [RL17] [RL15] [RL16]
                  fail_q <= ph_rdata[`NFC_ST_FAIL];   // [RL6] [RL10]
                  st_q <= S_IDLE;
               end
            default:
               st_q <= S_IDLE;
         endcase
      end
   end
endmodule // nfc_seq_top
`default_nettype wire

// ===== verif/nfc_seq_monitor.sv
`timescale 1ns/1ns
`default_nettype none
//-----------------------
// Flash pin checks
//-----------------------
module nfc_seq_monitor
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       nrst,
   // Flash pins
   input wire logic       cle,
   input wire logic       ale,
   input wire logic       write_strobe_n,
   input wire logic       read_strobe_n,
   input wire logic [7:0] io_out,
   input wire logic       io_oe_n,
   input wire logic       ready_busy_n
);
   logic       ws_q;
   logic       cle_q;
   logic [7:0] io_q;
   logic [7:0] cmd_q;
   wire        cmd_end = write_strobe_n && !ws_q && cle_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   //-----------------------
   // Last command, judged when its strobe rises
   //-----------------------
   always @(posedge clk_sys)
   begin
      ws_q  <= write_strobe_n || !nrst;
      cle_q <= write_strobe_n ? cle_q : cle;
      io_q  <= write_strobe_n ? io_q : io_out;
      cmd_q <= !nrst ? 8'hFF : cmd_end ? io_q : cmd_q;
   end
   a_strobes_apart: assert property (write_strobe_n || read_strobe_n) else $error("both strobes low");
   a_drive_on_write: assert property (!write_strobe_n |-> !io_oe_n) else $error("write without drive");
   a_float_on_read: assert property (!read_strobe_n |-> io_oe_n) else $error("driving during read");
   a_latch_apart: assert property (!(cle && ale)) else $error("both latches high");
   a_strobe_width: assert property ($fell(write_strobe_n) |-> (!write_strobe_n) [*3] ##1 write_strobe_n)
      else $error("write strobe width");
   a_pins_steady: assert property (!write_strobe_n && !$past(write_strobe_n) |-> $stable({cle, ale, io_out}))
      else $error("pins moved in strobe");
   a_erase_order: assert property (cmd_end && io_q == 8'hD0 |-> cmd_q == 8'h60)
      else $error("erase confirm without setup");
   a_prog_order: assert property (cmd_end && io_q == 8'h10 |-> cmd_q == 8'h85)
      else $error("program confirm without copy input");
   a_busy_cmds: assert property (cmd_end && !$past(ready_busy_n) |-> io_q inside {8'h70, 8'hF1, 8'hFF})
      else $error("command sent while busy");
endmodule // nfc_seq_monitor
bind nfc_seq_top nfc_seq_monitor u_nfc_seq_monitor (.clk_sys, .nrst, .cle, .ale, .write_strobe_n, .read_strobe_n,
   .io_out, .io_oe_n, .ready_busy_n);
`default_nettype wire

// ===== verif/nfc_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module nfc_flash_model
#(
   parameter int          erase_duration = 2000,
   parameter int          prog_ns        = 1200,
   parameter int          load_ns        = 400,
   // Arbitrary identification bytes
   parameter logic [39:0] id_bytes       = 40'h11_22_33_44_55
)
(
   // Host pins
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic [7:0] io_out,
   // Bench control
   input  wire logic       fail_next,
   // Device outputs
   output wire logic [7:0] io_drv,
   output var  logic       ready_busy_n
);
   logic [7:0] mode_q = 8'hFF;
   logic [7:0] data_q = 8'h00;
   logic [7:0] last_q = 8'h5A;
   logic       fail_q = 1'b0;
   int         adr_n = 0;
   int         rd_n = 0;
   int         dur = 0;
   logic [7:0] patch_q = 8'h00;
   // Live status: no strobe toggle needed to see a change
   wire  [7:0] st70 = {1'b1, ready_busy_n, ready_busy_n, 4'h0, fail_q};
   wire  [7:0] stf1 = {1'b1, ready_busy_n, ready_busy_n, 3'h0, fail_q, fail_q};
   wire  [7:0] shown = mode_q == 8'h70 ? st70 : mode_q == 8'hF1 ? stf1 : data_q;
   wire        go = (io_out == 8'h10 && mode_q == 8'h85) || (io_out == 8'hD0 && mode_q == 8'h60 && adr_n == 3) ||
                    (io_out == 8'h35 && mode_q == 8'h00 && adr_n == 5);
   initial ready_busy_n = 1'b1;
   // Released bus shows the inverse of the last byte
   assign io_drv = read_strobe_n ? ~last_q : shown;
   always @* if (!read_strobe_n) last_q = shown;
   always @(posedge write_strobe_n)
   begin
      if (cle && (ready_busy_n || io_out inside {8'h70, 8'hF1, 8'hFF}))
      begin
         fail_q = io_out == 8'hFF ? 1'b0 : go && io_out != 8'h35 ? fail_next : fail_q;
         dur = io_out == 8'hD0 ? erase_duration : io_out == 8'h10 ? prog_ns : load_ns;
         if (go)
            ready_busy_n = 1'b0;
         mode_q = go && io_out != 8'h35 ? 8'h70 : io_out;
         adr_n = 0;
         rd_n = 0;
      end
      else if (ale)
         adr_n++;
      else if (!cle)
         patch_q = io_out;
   end
   always
   begin
      wait (!ready_busy_n);
      #(dur);
      ready_busy_n = 1'b1;
   end
   always @(negedge read_strobe_n)
   begin
      data_q = mode_q != 8'h90 ? 8'(rd_n) ^ 8'h3C : rd_n < 5 ? id_bytes[39 - 8 * rd_n -: 8] : 8'h00;
      rd_n++;
   end
endmodule // nfc_flash_model
`default_nettype wire

// ===== verif/nfc_seq_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module nfc_seq_tb_top;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fail_next = 1'b0, saw_busy = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        cle, ale, write_strobe_n, read_strobe_n, io_oe_n, ready_busy_n;
   logic [7:0]  io_out, io_drv;
   wire  [7:0]  io_in = io_oe_n ? io_drv : io_out;
   int          failures = 0, n_compared = 0;
   nfc_seq_top u_nfc_seq_top (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cle, .ale,
      .write_strobe_n, .read_strobe_n, .io_out, .io_oe_n, .io_in, .ready_busy_n);
   nfc_flash_model u_nfc_flash_model (.cle, .ale, .write_strobe_n, .read_strobe_n, .io_out, .fail_next, .io_drv,
      .ready_busy_n);
   initial forever #4 clk_sys = ~clk_sys;
   always @(negedge ready_busy_n) saw_busy = 1'b1;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic hang;
      failures++;
      give_verdict;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 100) hang;
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 100) hang;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Start an operation and poll until the sequencer is idle
   task automatic run_op(input logic [2:0] op, input logic [11:0] cnt, input logic extra);
      int n;
      saw_busy = 1'b0;
      wr(4'h0, {1'b1, 15'h0, cnt, 1'b0, op});
      if (extra) wr(4'h0, {1'b1, 15'h0, 12'd1, 1'b0, 3'd4});
      for (n = 0; n < 400; n++)
      begin
         rdr(4'hC);
         if (rd[8] === 1'b0) break;
      end
      if (n == 400) hang;
   endtask
   task automatic t_status(input logic [2:0] op, input logic [7:0] exp);
      run_op(op, 12'd1, 1'b0);
      rdr(4'hC);
      check(rd[7:0], exp);
      $display("status op %0d done", op);
   endtask
   task automatic t_erase(input logic f);
      fail_next <= f;
      wr(4'h4, 32'h0302_0000);
      run_op(3'd3, 12'd0, f);
      check(saw_busy, 1'b1);
      check(ready_busy_n, 1'b1);
      rdr(4'hC);
      check({rd[10], rd[7:0]}, {f, 7'h60, f});
      $display("erase fail %0d done", f);
   endtask
   task automatic t_copy(input logic f);
      fail_next <= f;
      wr(4'h4, 32'h0004_0000);
      run_op(3'd1, 12'd3, 1'b0);
      rdr(4'h8);
      check(rd[8:0], 9'h13E);
      wr(4'h8, 32'h0000_00A5);
      run_op(3'd2, 12'd1, 1'b0);
      check(saw_busy, 1'b1);
      check(u_nfc_flash_model.patch_q, 8'hA5);
      rdr(4'hC);
      check(rd[7:0], {7'h60, f});
      $display("copy-back done");
   endtask
   task automatic t_regs;
      rdr(4'hC);
      check(rd[9:8], 2'b10);
      wr(4'hC, 32'h0);
      check(rsp, 2'b10);
      rdr(4'h2);
      check(rsp, 2'b10);
      $display("register access done");
   endtask
   task automatic t_id;
      run_op(3'd6, 12'd5, 1'b0);
      rdr(4'h8);
      check(rd[8:0], 9'h155);
      $display("read ID done");
   endtask
   initial
   begin
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      t_regs;
      t_status(3'd4, 8'hC0);
      t_status(3'd5, 8'hC0);
      t_erase(1'b0);
      t_erase(1'b1);
      t_status(3'd5, 8'hC3);
      run_op(3'd7, 12'd0, 1'b0);
      t_status(3'd4, 8'hC0);
      t_copy(1'b1);
      t_id;
      give_verdict;
   end
endmodule // nfc_seq_tb_top
`default_nettype wire
